/* File: hdl/see_device.sv */
// Purpose: Device end of a 1,024-bit serial EEPROM front end
// Assumes: Link pins are asynchronous to clock and sampled twice
// Notes: Array content has no reset, as in a non-volatile part
`timescale 1ns/1ps
module see_device
   import see_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // Serial link
   see_link_if.dev link,
   // Status
   output logic busy,
   output logic write_enabled
);
   localparam int TW = $clog2(PROG_CYCLES + 1);

   typedef enum logic [7:0] {
      DS_IDLE = 8'h01,
      DS_HEAD = 8'h02,
      DS_DATA = 8'h04,
      DS_READ = 8'h08,
      DS_ARMED = 8'h10,
      DS_DONE = 8'h20,
      DS_BUSY = 8'h40,
      DS_READY = 8'h80
   } see_dev_state_e;

   see_dev_state_e state_q;
   logic [1:0] cs_s, sk_s, din_s, osel_s;
   logic sk_prev_q, cs_prev_q;
   logic [4:0] cnt_q;
   logic [8:0] hdr_q;
   logic [1:0] op_q;
   logic [1:0] ext_q;
   logic [6:0] addr_q;
   logic [15:0] wd_q;
   logic [15:0] rd_sr_q;
   logic dout_q;
   logic wen_q;
   logic [TW-1:0] timer_q;
   logic [7:0] mem_q [MEM_BYTES];

   // Only the second flop of each synchroniser is read
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cs_s <= 2'h0;
         sk_s <= 2'h0;
         din_s <= 2'h0;
         osel_s <= 2'h3;
         sk_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end else begin
         cs_s <= {cs_s[0], link.cs};
         sk_s <= {sk_s[0], link.sk};
         din_s <= {din_s[0], link.din};
         osel_s <= {osel_s[0], link.organization_select};
         sk_prev_q <= sk_s[1];
         cs_prev_q <= cs_s[1];
      end
   end

   logic cs_lvl, sk_rise, cs_fall, din_b, word_mode;
   logic [4:0] hdr_last, data_last;
   assign cs_lvl = cs_s[1];
   assign sk_rise = sk_s[1] & ~sk_prev_q & cs_lvl;
   assign cs_fall = cs_prev_q & ~cs_lvl;
   assign din_b = din_s[1];
   assign word_mode = osel_s[1];
   // Header is opcode plus address; the start bit is not counted here
   assign hdr_last = word_mode ? 5'(ADDR_W_WORD + 1) : 5'(ADDR_W_BYTE + 1);
   assign data_last = word_mode ? 5'(DATA_W_WORD - 1) : 5'(DATA_W_BYTE - 1);

   // Header decode on the last address bit
   logic [8:0] hdr_next;
   logic [1:0] dec_op, dec_ext;
   logic [6:0] dec_addr;
   logic hdr_done;
   assign hdr_next = {hdr_q[7:0], din_b};
   assign dec_op = word_mode ? hdr_next[7:6] : hdr_next[8:7];
   assign dec_addr = word_mode ? {1'b0, hdr_next[5:0]} : hdr_next[6:0];
   assign dec_ext = word_mode ? dec_addr[5:4] : dec_addr[6:5];
   assign hdr_done = (state_q == DS_HEAD) && sk_rise && (cnt_q == hdr_last);

   // Location fetch, high byte of a word sits at the odd byte
   function automatic logic [15:0] fetch(input logic [6:0] a, input logic wm);
      logic [15:0] v;
      v = wm ? {mem_q[{a[5:0], 1'b1}], mem_q[{a[5:0], 1'b0}]} : {mem_q[a], 8'h00};
      return v;
   endfunction

   logic [6:0] next_addr;
   assign next_addr = word_mode ? {1'b0, addr_q[5:0] + 6'h01} : addr_q + 7'h01;

   logic prog_go, prog_end;
   assign prog_go = (state_q == DS_ARMED) && cs_fall && wen_q;
   assign prog_end = (state_q == DS_BUSY) && (timer_q == TW'(PROG_CYCLES - 1));

   // Instruction sequencer; nothing moves without a link edge except programming
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= DS_IDLE;
         cnt_q <= 5'h00;
         hdr_q <= 9'h000;
         op_q <= OP_EXT;
         ext_q <= EXT_WRITE_DISABLE;
         addr_q <= 7'h00;
         wd_q <= 16'h0000;
         rd_sr_q <= 16'h0000;
      end else begin
         unique case (state_q)
            DS_IDLE, DS_READY: begin
               if (!cs_lvl) begin
                  state_q <= DS_IDLE;
               end else if (sk_rise && din_b) begin
                  state_q <= DS_HEAD;
                  cnt_q <= 5'h00;
               end
            end
            DS_HEAD: begin
               if (!cs_lvl) begin
                  state_q <= DS_IDLE;
               end else if (sk_rise) begin
                  hdr_q <= hdr_next;
                  cnt_q <= cnt_q + 5'h01;
                  if (hdr_done) begin
                     op_q <= dec_op;
                     ext_q <= dec_ext;
                     addr_q <= dec_addr;
                     cnt_q <= 5'h00;
                     if (dec_op == OP_READ) begin
                        state_q <= DS_READ;
                        rd_sr_q <= fetch(dec_addr, word_mode);
                     end else if (dec_op == OP_WRITE ||
                                  (dec_op == OP_EXT && dec_ext == EXT_WRITE_ALL)) begin
                        state_q <= DS_DATA;
                     end else if (dec_op == OP_ERASE ||
                                  (dec_op == OP_EXT && dec_ext == EXT_ERASE_ALL)) begin
                        state_q <= DS_ARMED;
                     end else begin
                        state_q <= DS_DONE;
                     end
                  end
               end
            end
            DS_DATA: begin
               if (!cs_lvl) begin
                  state_q <= DS_IDLE;
               end else if (sk_rise) begin
                  wd_q <= {wd_q[14:0], din_b};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == data_last) begin
                     state_q <= DS_ARMED;
                  end
               end
            end
            DS_READ: begin
               if (!cs_lvl) begin
                  state_q <= DS_IDLE;
               end else if (sk_rise) begin
                  if (cnt_q == data_last) begin
                     cnt_q <= 5'h00;
                     addr_q <= next_addr;
                     rd_sr_q <= fetch(next_addr, word_mode);
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                     rd_sr_q <= {rd_sr_q[14:0], 1'b0};
                  end
               end
            end
            DS_ARMED: begin
               // A surplus clock spoils the instruction rather than guessing
               if (cs_fall) begin
                  state_q <= wen_q ? DS_BUSY : DS_IDLE;
               end else if (sk_rise) begin
                  state_q <= DS_DONE;
               end
            end
            DS_DONE: begin
               if (!cs_lvl) begin
                  state_q <= DS_IDLE;
               end
            end
            DS_BUSY: begin
               // Deselect does not stop an internal cycle
               if (prog_end) begin
                  state_q <= cs_lvl ? DS_READY : DS_IDLE;
               end
            end
            default: state_q <= DS_IDLE;
         endcase
      end
   end

   // Write-enable latch; reset stands in for power-up
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wen_q <= 1'b0;
      end else if (hdr_done && dec_op == OP_EXT) begin
         if (dec_ext == EXT_WRITE_ENABLE) begin
            wen_q <= 1'b1;
         end else if (dec_ext == EXT_WRITE_DISABLE) begin
            wen_q <= 1'b0;
         end
      end
   end

   // Self-timed cycle counter, runs on the system clock only
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         timer_q <= '0;
      end else if (prog_go) begin
         timer_q <= '0;
      end else if (state_q == DS_BUSY) begin
         timer_q <= timer_q + TW'(1);
      end
   end

   // Serial output: read data, busy zero, otherwise ready one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dout_q <= 1'b1;
      end else if (hdr_done && dec_op == OP_READ) begin
         dout_q <= 1'b0;
      end else if (state_q == DS_READ && cs_lvl) begin
         if (sk_rise) begin
            dout_q <= rd_sr_q[15];
         end
      end else if (prog_go || state_q == DS_BUSY) begin
         dout_q <= prog_end ? 1'b1 : 1'b0;
      end else begin
         dout_q <= 1'b1;
      end
   end

   // Array update; the addressed location, or every one for the all ops, changes in the cycle programming starts
   logic all_op, erase_op;
   assign all_op = (op_q == OP_EXT);
   assign erase_op = (op_q == OP_ERASE) || (op_q == OP_EXT && ext_q == EXT_ERASE_ALL);
   for (genvar i = 0; i < MEM_BYTES; i++) begin : g_mem
      localparam logic [6:0] IDX = 7'(i);
      logic hit;
      assign hit = all_op || (word_mode ? (addr_q[5:0] == IDX[6:1]) : (addr_q == IDX));
      always_ff @(posedge clock) begin
         if (prog_go && hit) begin
            if (erase_op) begin
               mem_q[i] <= ERASED_BYTE;
            end else begin
               mem_q[i] <= (word_mode && IDX[0]) ? wd_q[15:8] : wd_q[7:0];
            end
         end
      end
   end

   assign link.dout = dout_q;
   assign busy = (state_q == DS_BUSY);
   assign write_enabled = wen_q;
endmodule

/* File: inc/see_pkg.sv */
// Purpose: Shared constants and types for the serial EEPROM front end
// Assumes: 40 MHz system clock on both ends
// Notes: Instruction codes and frame sizes are used by both ends
package see_pkg;
   // Clock and time constants
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 5000000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS; // Longest time, rounded down
   localparam int TCS_NS = 200;
   localparam int TCS_CYCLES = (TCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Least time, up
   localparam int SK_HALF_CYCLES_DEF = 8;

   // Array geometry
   localparam int MEM_BYTES = 128;
   localparam int ADDR_W_BYTE = 7;
   localparam int ADDR_W_WORD = 6;
   localparam int DATA_W_BYTE = 8;
   localparam int DATA_W_WORD = 16;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // Operation codes and extended selectors
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] EXT_WRITE_DISABLE = 2'h0;
   localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
   localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
   localparam logic [1:0] EXT_WRITE_ENABLE = 2'h3;

   // Host command kinds
   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_ERASE = 3'h2,
      CMD_WRITE_ALL = 3'h3,
      CMD_ERASE_ALL = 3'h4,
      CMD_WRITE_ENABLE = 3'h5,
      CMD_WRITE_DISABLE = 3'h6
   } see_cmd_e;
endpackage

/* File: inc/see_link_if.sv */
// Purpose: Three-wire serial link plus organization strap
// Assumes: Host makes the serial clock; bench drives the strap (1 when floating)
// Notes: All wires are one-way, no enables needed
`timescale 1ns/1ps
interface see_link_if;
   logic cs;
   logic sk;
   logic din;
   logic dout;
   logic organization_select;

   // Device end
   modport dev (input cs, input sk, input din, input organization_select, output dout);
   // Host end
   modport host (output cs, output sk, output din, input dout);
endinterface

/* File: hdl/see_host.sv */
// Purpose: Host end driving the three-wire serial EEPROM link
// Assumes: Caller knows the strap setting and gives it as word_mode
// Notes: Serial clock is a divided system clock, never stretched
`timescale 1ns/1ps
module see_host
   import see_pkg::*;
#(
   parameter int SK_HALF = SK_HALF_CYCLES_DEF
) (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // Serial link
   see_link_if.host link,
   // Command request
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire see_cmd_e cmd_kind,
   input wire logic [6:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   input wire logic [7:0] cmd_count,
   input wire logic word_mode,
   // Results
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic done
);
   localparam int HW = $clog2(SK_HALF + TCS_CYCLES + 1);

   typedef enum logic [6:0] {
      HS_IDLE = 7'h01,
      HS_LOW = 7'h02,
      HS_HIGH = 7'h04,
      HS_TAIL = 7'h08,
      HS_WAIT = 7'h10,
      HS_POLL = 7'h20,
      HS_GAP = 7'h40
   } see_host_state_e;

   see_host_state_e state_q;
   logic [1:0] dout_s;
   logic [HW-1:0] div_q;
   logic [24:0] frame_q;
   logic [11:0] tick_q, ticks_q;
   logic [3:0] rbit_q;
   logic [15:0] rsr_q;
   logic is_read_q, is_prog_q, wm_q, cs_q, sk_q, din_q;

   // Frame assembly from the command
   logic [1:0] op;
   logic [6:0] af;
   logic [11:0] hdr, ticks;
   always_comb begin
      op = OP_EXT;
      af = 7'h00;
      unique case (cmd_kind)
         CMD_READ: op = OP_READ;
         CMD_WRITE: op = OP_WRITE;
         CMD_ERASE: op = OP_ERASE;
         CMD_WRITE_ALL: af = {EXT_WRITE_ALL, 5'h00};
         CMD_ERASE_ALL: af = {EXT_ERASE_ALL, 5'h00};
         CMD_WRITE_ENABLE: af = {EXT_WRITE_ENABLE, 5'h00};
         CMD_WRITE_DISABLE: af = {EXT_WRITE_DISABLE, 5'h00};
         default: af = 7'h00;
      endcase
      if (op != OP_EXT) begin
         af = cmd_addr;
      end
      hdr = word_mode ? 12'(3 + ADDR_W_WORD) : 12'(3 + ADDR_W_BYTE);
      ticks = hdr;
      if (cmd_kind == CMD_WRITE || cmd_kind == CMD_WRITE_ALL) begin
         ticks = hdr + (word_mode ? 12'(DATA_W_WORD) : 12'(DATA_W_BYTE));
      end else if (cmd_kind == CMD_READ) begin
         ticks = hdr + (word_mode ? {cmd_count, 4'h0} : {1'b0, cmd_count, 3'h0});
      end
   end

   logic phase_end, sample, dw_last;
   logic [11:0] first_data;
   assign phase_end = (div_q == HW'(SK_HALF - 1));
   assign first_data = (wm_q ? 12'(3 + ADDR_W_WORD) : 12'(3 + ADDR_W_BYTE)) + 12'h001;
   // Sample just before the next rise, long after the device moved its output
   assign sample = is_read_q && phase_end &&
                   ((state_q == HS_LOW && tick_q >= first_data) || state_q == HS_TAIL);
   assign dw_last = (rbit_q == (wm_q ? 4'(DATA_W_WORD - 1) : 4'(DATA_W_BYTE - 1)));

   // Returned data passes two flops before use
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dout_s <= 2'h0;
      end else begin
         dout_s <= {dout_s[0], link.dout};
      end
   end

   // Link sequencer and clock divider
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= HS_IDLE;
         div_q <= '0;
         frame_q <= 25'h0000000;
         tick_q <= 12'h000;
         ticks_q <= 12'h000;
         is_read_q <= 1'b0;
         is_prog_q <= 1'b0;
         wm_q <= 1'b0;
         cs_q <= 1'b0;
         sk_q <= 1'b0;
         din_q <= 1'b0;
      end else begin
         div_q <= phase_end ? '0 : div_q + HW'(1);
         unique case (state_q)
            HS_IDLE: begin
               div_q <= '0;
               if (cmd_valid) begin
                  frame_q <= word_mode ? {1'b1, op, af[5:0], cmd_data}
                                       : {1'b1, op, af, cmd_data[7:0], 7'h00};
                  din_q <= 1'b1;
                  cs_q <= 1'b1;
                  tick_q <= 12'h000;
                  ticks_q <= ticks;
                  wm_q <= word_mode;
                  is_read_q <= (cmd_kind == CMD_READ);
                  is_prog_q <= (cmd_kind inside {CMD_WRITE, CMD_ERASE, CMD_WRITE_ALL,
                                                 CMD_ERASE_ALL});
                  state_q <= HS_LOW;
               end
            end
            HS_LOW: if (phase_end) begin
               sk_q <= 1'b1;
               state_q <= HS_HIGH;
            end
            HS_HIGH: if (phase_end) begin
               sk_q <= 1'b0;
               frame_q <= {frame_q[23:0], 1'b0};
               din_q <= frame_q[23];
               tick_q <= tick_q + 12'h001;
               state_q <= (tick_q == ticks_q - 12'h001) ? HS_TAIL : HS_LOW;
            end
            HS_TAIL: if (phase_end) begin
               cs_q <= 1'b0;
               din_q <= 1'b0;
               state_q <= is_prog_q ? HS_WAIT : HS_GAP;
            end
            HS_WAIT: if (div_q == HW'(TCS_CYCLES - 1)) begin
               cs_q <= 1'b1;
               state_q <= HS_POLL;
            end
            HS_POLL: if (phase_end && dout_s[1]) begin
               cs_q <= 1'b0;
               state_q <= HS_GAP;
            end
            HS_GAP: if (phase_end) begin
               state_q <= HS_IDLE;
            end
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   // Read word collection, first bit is the most significant
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rbit_q <= 4'h0;
         rsr_q <= 16'h0000;
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         if (state_q == HS_IDLE) begin
            rbit_q <= 4'h0;
         end else if (sample) begin
            rsr_q <= {rsr_q[14:0], dout_s[1]};
            rbit_q <= dw_last ? 4'h0 : rbit_q + 4'h1;
            if (dw_last) begin
               // In byte mode the shifter still holds the previous byte, so clear it off
               rd_data <= wm_q ? {rsr_q[14:0], dout_s[1]} : {8'h00, rsr_q[6:0], dout_s[1]};
               rd_valid <= 1'b1;
            end
         end
      end
   end

   // Completion pulse at the end of the deselect gap
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         done <= 1'b0;
      end else begin
         done <= (state_q == HS_GAP) && phase_end;
      end
   end

   assign cmd_ready = (state_q == HS_IDLE);
   assign link.cs = cs_q;
   assign link.sk = sk_q;
   assign link.din = din_q;
endmodule

/* File: bench/see_link_properties.sv */
// Purpose: Wire-level checks on the link between host and device ends
// Assumes: Host serial clock high phase spans several system clocks
// Notes: Rise count is cleared while chip select is low
`timescale 1ns/1ps
module see_link_properties
   import see_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // Link
   input wire logic cs,
   input wire logic sk,
   input wire logic din,
   input wire logic dout,
   input wire logic organization_select
);
   logic sk_q;
   logic [7:0] rise_q;
   logic [1:0] op_q;
   int wait_q;
   logic [7:0] hdr;

   // Header length with start bit, per organization
   assign hdr = organization_select ? 8'h09 : 8'h0A;

   // Delayed serial clock for edge finding
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) sk_q <= 1'b0;
      else sk_q <= sk;
   end

   // Rises within the current frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) rise_q <= 8'h00;
      else if (!cs) rise_q <= 8'h00;
      else if (sk && !sk_q) rise_q <= rise_q + 8'h01;
   end

   // Opcode taken from the two bits after the start bit
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) op_q <= 2'h0;
      else if (cs && sk && !sk_q && (rise_q == 8'h01 || rise_q == 8'h02)) op_q <= {op_q[0], din};
   end

   // Length of a busy poll, so a stuck cycle is caught
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) wait_q <= 0;
      else wait_q <= (cs && rise_q == 8'h00 && !dout) ? wait_q + 1 : 0;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   property p_sk_cs; $rose(sk) |-> cs && $past(cs); endproperty
   a_sk_cs: assert property (p_sk_cs) else $error("clock rise without select");
   property p_din; sk |-> $stable(din); endproperty
   a_din: assert property (p_din) else $error("data moved while clock high");
   property p_start; $rose(sk) && rise_q == 8'h00 |-> din; endproperty
   a_start: assert property (p_start) else $error("start bit not one");
   property p_count; $fell(cs) |-> rise_q == 8'h00 || (organization_select ?
      (rise_q >= 8'h09 && rise_q[3:0] == 4'h9) : (rise_q >= 8'h0A && rise_q[2:0] == 3'h2));
   endproperty
   a_count: assert property (p_count) else $error("bad clock count in frame");
   property p_dummy; $rose(sk) && cs && op_q == OP_READ && rise_q == hdr - 8'h01
      |-> ##5 (!dout) [*8]; endproperty
   a_dummy: assert property (p_dummy) else $error("no leading zero on read");
   property p_rd_hold; $rose(sk) && cs && op_q == OP_READ && rise_q >= hdr
      |-> ##6 $stable(dout) [*8]; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("output moved off clock rise");
   property p_quiet; cs && rise_q != 8'h00 && (op_q != OP_READ || rise_q < hdr) |-> dout;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output driven outside read");
   property p_ready; cs && rise_q == 8'h00 && dout |=> dout || !cs; endproperty
   a_ready: assert property (p_ready) else $error("ready fell back to busy");
   property p_busy_len; wait_q <= PROG_CYCLES + 8; endproperty
   a_busy_len: assert property (p_busy_len) else $error("programming too long");
   property p_sk_idle; !cs |-> !sk; endproperty
   a_sk_idle: assert property (p_sk_idle) else $error("clock runs while deselected");
endmodule

/* File: bench/serial_eeprom_interface_tb.sv */
// Purpose: Host end and device end joined, driven through host commands
// Assumes: Short programming time parameter; strap changed only when idle
// Notes: Array is first erased, since it has no reset value
`timescale 1ns/1ps
module serial_eeprom_interface_tb
   import see_pkg::*;
;
   localparam int PROG = 50;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   see_cmd_e cmd_kind = CMD_READ;
   logic [6:0] cmd_addr = 7'h00;
   logic [15:0] cmd_data = 16'h0000;
   logic [7:0] cmd_count = 8'h00;
   logic cmd_ready, rd_valid, done, busy, write_enabled;
   logic busy_seen = 1'b0;
   logic [15:0] rd_data;
   logic [15:0] rq [$];
   int errors = 0;
   int check_count = 0;

   see_link_if see_link_if_i ();

   see_device #(.PROG_CYCLES(PROG)) see_device_i (.clock(clock), .reset_n(reset_n),
      .link(see_link_if_i.dev), .busy(busy), .write_enabled(write_enabled));

   see_host see_host_i (.clock(clock), .reset_n(reset_n), .link(see_link_if_i.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count),
      .word_mode(see_link_if_i.organization_select), .rd_data(rd_data),
      .rd_valid(rd_valid), .done(done));

   see_link_properties #(.PROG_CYCLES(PROG)) see_link_properties_i (.clock(clock),
      .reset_n(reset_n), .cs(see_link_if_i.cs), .sk(see_link_if_i.sk),
      .din(see_link_if_i.din), .dout(see_link_if_i.dout),
      .organization_select(see_link_if_i.organization_select));

   // 40 MHz system clock
   always #12.5 clock = ~clock;

   // Gather streamed locations and note any programming cycle, away from the launching edge
   always @(negedge clock) begin
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (busy === 1'b1) busy_seen = 1'b1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One host command, waited on under a bound so a lost done cannot hang
   task automatic cmd(input see_cmd_e k, input logic [6:0] a, input logic [15:0] d,
         input logic [7:0] n);
      int t;
      @(negedge clock);
      cmd_kind = k;
      cmd_addr = a;
      cmd_data = d;
      cmd_count = n;
      cmd_valid = 1'b1;
      // Ready is looked at on the falling edge, never in the edge that moves it
      while (cmd_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 20000) begin
         @(negedge clock);
         t++;
      end
      if (t >= 20000) errors++;
   endtask

   task automatic rdx(input logic [6:0] a, input int n, input logic [15:0] e [8]);
      rq.delete();
      cmd(CMD_READ, a, 16'h0000, 8'(n));
      chk(16'(rq.size()), 16'(n));
      for (int i = 0; i < n; i++) chk(rq[i], e[i]);
   endtask

   task automatic flags(input logic [15:0] exp);
      chk({14'h0000, write_enabled, busy_seen}, exp);
   endtask

   task automatic end_sim;
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #(90000 * 25);
      errors++;
      end_sim();
   end

   // Byte organization first, then words over the same array
   initial begin
      see_link_if_i.organization_select = 1'b0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      flags(16'h0000);
      cmd(CMD_WRITE_ENABLE, 7'h00, 16'h0000, 8'h00);
      cmd(CMD_ERASE_ALL, 7'h00, 16'h0000, 8'h00);
      flags(16'h0003);
      cmd(CMD_WRITE_DISABLE, 7'h00, 16'h0000, 8'h00);
      busy_seen = 1'b0;
      cmd(CMD_WRITE, 7'h05, 16'h00A5, 8'h00);
      cmd(CMD_ERASE, 7'h04, 16'h0000, 8'h00);
      flags(16'h0000);
      rdx(7'h7E, 8, '{default: 16'h00FF});
      cmd(CMD_WRITE_ENABLE, 7'h00, 16'h0000, 8'h00);
      cmd(CMD_WRITE, 7'h7F, 16'h003C, 8'h00);
      cmd(CMD_WRITE, 7'h00, 16'h00C3, 8'h00);
      cmd(CMD_WRITE, 7'h01, 16'h005A, 8'h00);
      cmd(CMD_ERASE, 7'h01, 16'h0000, 8'h00);
      cmd(CMD_WRITE, 7'h02, 16'h0011, 8'h00);
      rdx(7'h7E, 5, '{16'h00FF, 16'h003C, 16'h00C3, 16'h00FF, 16'h0011, 16'h0000, 16'h0000,
         16'h0000});
      cmd(CMD_WRITE_ALL, 7'h00, 16'h0096, 8'h00);
      rdx(7'h7F, 2, '{default: 16'h0096});
      @(negedge clock);
      see_link_if_i.organization_select = 1'b1;
      repeat (4) @(negedge clock);
      cmd(CMD_WRITE, 7'h03, 16'h1234, 8'h00);
      rdx(7'h3F, 5, '{16'h9696, 16'h9696, 16'h9696, 16'h9696, 16'h1234, 16'h0000, 16'h0000,
         16'h0000});
      @(negedge clock);
      see_link_if_i.organization_select = 1'b0;
      repeat (4) @(negedge clock);
      rdx(7'h06, 3, '{16'h0034, 16'h0012, 16'h0096, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
         16'h0000});
      cmd(CMD_WRITE_DISABLE, 7'h00, 16'h0000, 8'h00);
      chk({15'h0000, write_enabled}, 16'h0000);
      end_sim();
   end
endmodule
